// file: hw/msg_framer.v
// Purpose: Slave message framer for ASCII and RTU serial frames
// Assumes: Byte stream from a UART; one clock
// Notes:   Application builds normal replies; framer adds address,
//          checksum and delimiters, and answers command and data errors
//
// The address map and strobed register access were decided locally.
`timescale 1ns/1ps
`include "framer_consts.vh"
module msg_framer #(
    parameter CYC_PER_MS = `CYC_PER_MS
) (
    input  wire        i_sys_clk,
    input  wire        i_nrst,
    input  wire [1:0]  i_reg_addr,
    input  wire [7:0]  i_reg_wdata,
    input  wire        i_reg_wr,
    input  wire        i_reg_rd,
    output wire [7:0]  o_reg_rdata,
    input  wire [7:0]  i_rx_data,
    input  wire        i_rx_valid,
    output wire [7:0]  o_tx_data,
    output wire        o_tx_valid,
    input  wire        i_tx_ready,
    output wire        o_frame_rdy,
    input  wire        i_proc_grant,
    output wire        o_req,
    output wire [7:0]  o_cmd,
    output wire [15:0] o_start,
    output wire [4:0]  o_count,
    input  wire [3:0]  i_wd_idx,
    output wire [15:0] o_wd,
    input  wire [7:0]  i_rsp_data,
    input  wire        i_rsp_valid,
    input  wire        i_rsp_last,
    output wire        o_rsp_rdy
);
    localparam S_HUNT = 6'h01, S_RX = 6'h02, S_LF = 6'h04;
    localparam S_CHK  = 6'h08, S_WAIT = 6'h10, S_TX = 6'h20;
    localparam P_COLON = 8'h01, P_ADDR = 8'h02, P_BODY = 8'h04, P_CKS = 8'h08;
    localparam P_CKS2  = 8'h10, P_CR = 8'h20, P_LF = 8'h40, P_END = 8'h80;

    reg [7:0]  mem [0:`BUF_DEPTH-1];
    reg [5:0]  st_q;
    reg [7:0]  tph_q;
    reg [6:0]  cnt_q;
    reg        ovf_q;
    reg        hi_q;
    reg [3:0]  hnib_q;
    reg [7:0]  lrc_rx_q;
    reg [15:0] crc_rx_q;
    reg [17:0] pre_q;
    reg [4:0]  ms_q;
    reg [2:0]  ctrl_q;
    reg [6:0]  staddr_q;
    reg [7:0]  disc_q;
    reg [7:0]  rdata_q;
    reg        exc_q;
    reg        eidx_q;
    reg [7:0]  code_q;
    reg [7:0]  cmd_q;
    reg [15:0] start_q;
    reg [4:0]  count_q;
    reg        req_q;
    reg [15:0] wd_q;
    reg [7:0]  tx_data_q;
    reg        tx_valid_q;
    reg        hold_q;
    reg [7:0]  tb_q;
    reg [7:0]  lrc_tx_q;
    reg [15:0] crc_tx_q;
    reg [7:0]  slot_q;
    reg        slot_full_q;
    reg        slot_last_q;
    reg        rsp_rdy_q;

    wire        rtu = ctrl_q[0];
    wire [6:0]  rx_ch = i_rx_data[6:0];
    wire [3:0]  dec_nib;
    wire        dec_ok;
    wire [7:0]  enc_ch;
    wire [15:0] crc_rx_n;
    wire [15:0] crc_tx_n;
    wire [7:0]  rx_byte = rtu ? i_rx_data : {hnib_q, dec_nib};
    wire        can_load = !tx_valid_q || i_tx_ready;
    reg         put;
    reg [7:0]   pb;

    // Idle time for the selected line rate
    function [4:0] idle_ms;
        input [1:0] sel;
        case (sel)
            2'h0:    idle_ms = `IDLE_MS_4800;
            2'h1:    idle_ms = `IDLE_MS_9600;
            2'h2:    idle_ms = `IDLE_MS_19200;
            default: idle_ms = `IDLE_MS_38400;
        endcase
    endfunction

    hex_char_codec u_hex (
        .i_char   (rx_ch),
        .i_nib    (hold_q ? tb_q[3:0] : pb[7:4]),
        .o_nib    (dec_nib),
        .o_is_hex (dec_ok),
        .o_char   (enc_ch)
    );

    // The first byte of an RTU frame starts from the preset value
    crc16_step u_crc_rx (
        .i_crc  ((st_q == S_HUNT) ? `CRC_PRESET : crc_rx_q),
        .i_byte (rx_byte),
        .o_crc  (crc_rx_n)
    );

    crc16_step u_crc_tx (
        .i_crc  (crc_tx_q),
        .i_byte (pb),
        .o_crc  (crc_tx_n)
    );

    // Frame check: checksum, length, address and command decode
    wire [6:0] ckb      = rtu ? 7'h2 : 7'h1;
    wire [7:0] bcmd     = mem[1];
    wire [15:0] nwords  = {mem[4], mem[5]};
    wire       words_ok = (nwords != 16'h0) && (nwords <= {8'h00, `MAX_WORDS});
    wire       sum_ok   = rtu ? (crc_rx_q == 16'h0000) : (lrc_rx_q == 8'h00);
    wire       addr_ok  = (staddr_q != 7'h00) && (mem[0] == {1'b0, staddr_q});
    wire       frame_ok = !ovf_q && (cnt_q >= 7'h2 + ckb) && sum_ok && addr_ok;
    wire       rd_ok    = (cnt_q == 7'h6 + ckb) && words_ok;
    wire       wr_ok    = words_ok && (mem[6] == {nwords[6:0], 1'b0}) &&
                          (cnt_q == 7'h7 + {nwords[5:0], 1'b0} + ckb);
    wire [7:0] chk_code = (bcmd == `CMD_READ)  ? (rd_ok ? 8'h00 : `EXC_DATA) :
                          (bcmd == `CMD_WRITE) ? (wr_ok ? 8'h00 : `EXC_DATA) :
                          `EXC_CMD;
    wire [5:0] wd_hi    = 6'h7 + {1'b0, i_wd_idx, 1'b0};

    // Next byte to send on the line, chosen by transmit phase
    always @* begin
        put = 1'b0;
        pb  = 8'h00;
        if (st_q == S_TX && can_load && !hold_q) begin
            case (tph_q)
                P_ADDR: begin
                    put = 1'b1;
                    pb  = mem[0];
                end
                P_BODY: begin
                    if (exc_q) begin
                        put = 1'b1;
                        pb  = eidx_q ? code_q : (cmd_q | `EXC_FLAG);
                    end else if (slot_full_q) begin
                        put = 1'b1;
                        pb  = slot_q;
                    end
                end
                P_CKS: begin
                    put = 1'b1;
                    pb  = rtu ? crc_tx_q[7:0] : (8'h00 - lrc_tx_q);
                end
                P_CKS2: begin
                    put = 1'b1;
                    pb  = crc_tx_q[15:8];
                end
                default: put = 1'b0;
            endcase
        end
    end

    // Main sequencer
    always @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            // Datapath registers are loaded before use, so they carry no reset
            st_q        <= S_HUNT;
            tph_q       <= P_COLON;
            ctrl_q      <= `CTRL_RST;
            staddr_q    <= `STADDR_RST;
            disc_q      <= 8'h00;
            rdata_q     <= 8'h00;
            exc_q       <= 1'b0;
            cmd_q       <= 8'h00;
            start_q     <= 16'h0000;
            count_q     <= 5'h00;
            req_q       <= 1'b0;
            wd_q        <= 16'h0000;
            tx_data_q   <= 8'h00;
            tx_valid_q  <= 1'b0;
            hold_q      <= 1'b0;
            slot_full_q <= 1'b0;
            rsp_rdy_q   <= 1'b0;
        end else begin
            req_q <= 1'b0;
            wd_q  <= {mem[wd_hi], mem[wd_hi + 6'h1]};

            // Register port; the 7-bit field keeps the address in 0..127
            if (i_reg_wr) begin
                case (i_reg_addr)
                    `REG_CTRL:   ctrl_q   <= i_reg_wdata[2:0];
                    `REG_STADDR: staddr_q <= i_reg_wdata[6:0];
                    default:     ;
                endcase
            end
            if (i_reg_rd) begin
                case (i_reg_addr)
                    `REG_CTRL:   rdata_q <= {5'h00, ctrl_q};
                    `REG_STADDR: rdata_q <= {1'b0, staddr_q};
                    `REG_STATUS: rdata_q <= {5'h00, st_q[5], st_q[4], st_q[1] | st_q[2]};
                    default:     rdata_q <= disc_q;
                endcase
            end

            // Discard counter: hardware increment wins over software clear
            if (st_q == S_CHK && !frame_ok) begin
                disc_q <= disc_q + 8'h01;
            end else if (i_reg_wr && i_reg_addr == `REG_DISCARD) begin
                disc_q <= 8'h00;
            end

            // RTU idle timer restarts on each byte
            if (st_q == S_RX && rtu && !i_rx_valid) begin
                if (pre_q == CYC_PER_MS - 1) begin
                    pre_q <= 18'h00000;
                    ms_q  <= ms_q + 5'h01;
                end else begin
                    pre_q <= pre_q + 18'h00001;
                end
            end else begin
                pre_q <= 18'h00000;
                ms_q  <= 5'h00;
            end

            case (st_q)
                S_HUNT, S_RX, S_LF: begin
                    if (i_rx_valid && !rtu && rx_ch == `CH_COLON) begin
                        st_q     <= S_RX;
                        cnt_q    <= 7'h00;
                        ovf_q    <= 1'b0;
                        hi_q     <= 1'b0;
                        lrc_rx_q <= 8'h00;
                    end else if (i_rx_valid && rtu && st_q != S_LF) begin
                        st_q     <= S_RX;
                        crc_rx_q <= crc_rx_n;
                        if (st_q == S_HUNT) begin
                            cnt_q  <= 7'h01;
                            ovf_q  <= 1'b0;
                            mem[0] <= i_rx_data;
                        end else begin
                            if (cnt_q < `BUF_DEPTH) mem[cnt_q[5:0]] <= i_rx_data;
                            if (cnt_q < `BUF_DEPTH) cnt_q <= cnt_q + 7'h01;
                            else ovf_q <= 1'b1;
                        end
                    end else if (i_rx_valid && !rtu && st_q == S_RX) begin
                        if (rx_ch == `CH_CR) begin
                            st_q <= hi_q ? S_HUNT : S_LF;
                        end else if (!dec_ok) begin
                            st_q <= S_HUNT;
                        end else if (!hi_q) begin
                            hnib_q <= dec_nib;
                            hi_q   <= 1'b1;
                        end else begin
                            hi_q     <= 1'b0;
                            lrc_rx_q <= lrc_rx_q + rx_byte;
                            if (cnt_q < `BUF_DEPTH) mem[cnt_q[5:0]] <= rx_byte;
                            if (cnt_q < `BUF_DEPTH) cnt_q <= cnt_q + 7'h01;
                            else ovf_q <= 1'b1;
                        end
                    end else if (i_rx_valid && !rtu && st_q == S_LF) begin
                        st_q <= (rx_ch == `CH_LF) ? S_CHK : S_HUNT;
                    end else if (rtu && st_q == S_RX && ms_q == idle_ms(ctrl_q[2:1])) begin
                        st_q <= S_CHK;
                    end
                end
                S_CHK: begin
                    st_q    <= frame_ok ? S_WAIT : S_HUNT;
                    code_q  <= chk_code;
                    exc_q   <= (chk_code != 8'h00);
                    cmd_q   <= bcmd;
                    start_q <= {mem[2], mem[3]};
                    count_q <= nwords[4:0];
                end
                S_WAIT: begin
                    if (i_proc_grant) begin
                        st_q      <= S_TX;
                        tph_q     <= rtu ? P_ADDR : P_COLON;
                        req_q     <= !exc_q;
                        rsp_rdy_q <= !exc_q;
                        eidx_q    <= 1'b0;
                        lrc_tx_q  <= 8'h00;
                        crc_tx_q  <= `CRC_PRESET;
                    end
                end
                S_TX: begin
                    if (rsp_rdy_q && i_rsp_valid) begin
                        slot_q      <= i_rsp_data;
                        slot_last_q <= i_rsp_last;
                        slot_full_q <= 1'b1;
                        rsp_rdy_q   <= 1'b0;
                    end
                    if (can_load) begin
                        tx_valid_q <= 1'b0;
                        if (hold_q) begin
                            tx_data_q  <= enc_ch;
                            tx_valid_q <= 1'b1;
                            hold_q     <= 1'b0;
                        end else begin
                            if (put) begin
                                tx_valid_q <= 1'b1;
                                tx_data_q  <= rtu ? pb : enc_ch;
                                hold_q     <= !rtu;
                                tb_q       <= pb;
                            end
                            if (put && (tph_q == P_ADDR || tph_q == P_BODY)) begin
                                lrc_tx_q <= lrc_tx_q + pb;
                                crc_tx_q <= crc_tx_n;
                            end
                            case (tph_q)
                                P_COLON: begin
                                    tx_data_q  <= {1'b0, `CH_COLON};
                                    tx_valid_q <= 1'b1;
                                    tph_q      <= P_ADDR;
                                end
                                P_ADDR: tph_q <= P_BODY;
                                P_BODY: begin
                                    if (exc_q) begin
                                        eidx_q <= 1'b1;
                                        if (eidx_q) tph_q <= P_CKS;
                                    end else if (slot_full_q) begin
                                        slot_full_q <= 1'b0;
                                        rsp_rdy_q   <= !slot_last_q;
                                        if (slot_last_q) tph_q <= P_CKS;
                                    end
                                end
                                P_CKS:  tph_q <= rtu ? P_CKS2 : P_CR;
                                P_CKS2: tph_q <= P_END;
                                P_CR: begin
                                    tx_data_q  <= {1'b0, `CH_CR};
                                    tx_valid_q <= 1'b1;
                                    tph_q      <= P_LF;
                                end
                                P_LF: begin
                                    tx_data_q  <= {1'b0, `CH_LF};
                                    tx_valid_q <= 1'b1;
                                    tph_q      <= P_END;
                                end
                                default: st_q <= S_HUNT;
                            endcase
                        end
                    end
                end
                default: st_q <= S_HUNT;
            endcase
        end
    end

    assign o_reg_rdata = rdata_q;
    assign o_tx_data   = tx_data_q;
    assign o_tx_valid  = tx_valid_q;
    assign o_frame_rdy = st_q[4];
    assign o_req       = req_q;
    assign o_cmd       = cmd_q;
    assign o_start     = start_q;
    assign o_count     = count_q;
    assign o_wd        = wd_q;
    assign o_rsp_rdy   = rsp_rdy_q;
endmodule

// file: include/framer_consts.vh
// Functional notes
// - ASCII frame opens with colon and closes with CR then LF.
// - ASCII fields are hex characters, two per byte; address takes two.
// - A colon in any receive state restarts the frame.
// - Respond only when frame address equals the configured station address.
// - Station address zero means never respond.
// - Response echoes the received address byte.
// - LRC is two's complement of the byte sum, sent as two hex chars.
// - After LF the frame waits for processing permission.
// - RTU fields are raw bytes: one address byte, two checksum bytes.
// - CRC-16 preset FFFF, right shift, XOR A001 on carry out.
// - Final CRC bytes are exchanged, so low register byte goes first.
// - RTU frame ends after 16/8/4/2 ms idle by line rate.
// - Idle time may deviate by at most one millisecond.
// - Only read 03h and write 10h commands are recognised.
// - Abnormal codes: 01 command, 02 address, 03 data error; the framer never sends 02.
// - At most 16 data words per read or write.
// - Station address is zero or 1 to 127.
// - Abnormal reply returns command with MSB set, then the code.
// - RTU characters are always eight data bits.
//
// Purpose: Shared constants of the serial slave message framer
// Assumes: Included by the framer design files
// Notes:   Definitions only
`ifndef FRAMER_CONSTS_VH
`define FRAMER_CONSTS_VH

`define CH_COLON     7'h3a
`define CH_CR        7'h0d
`define CH_LF        7'h0a
`define CMD_READ     8'h03
`define CMD_WRITE    8'h10
`define EXC_FLAG     8'h80
`define EXC_CMD      8'h01
`define EXC_ADDR     8'h02
`define EXC_DATA     8'h03
`define MAX_WORDS    8'h10
`define CRC_PRESET   16'hffff
`define CRC_POLY     16'ha001
`define BUF_DEPTH    64
`define CLK_MHZ      200
`define CYC_PER_MS   (`CLK_MHZ * 1000)
`define IDLE_MS_4800  5'h10
`define IDLE_MS_9600  5'h08
`define IDLE_MS_19200 5'h04
`define IDLE_MS_38400 5'h02
`define REG_CTRL     2'h0
`define REG_STADDR   2'h1
`define REG_STATUS   2'h2
`define REG_DISCARD  2'h3
`define CTRL_RST     3'h4
`define STADDR_RST   7'h00

`endif

// file: hw/crc16_step.v
// Purpose: One-byte update of the CRC-16 register
// Assumes: Combinational; shared by receive and transmit
// Notes:   Eight shift steps unrolled by a loop
`timescale 1ns/1ps
`include "framer_consts.vh"
module crc16_step (
    input  wire [15:0] i_crc,
    input  wire [7:0]  i_byte,
    output reg  [15:0] o_crc
);
    integer n;

    // Byte enters the low end, then eight right shifts
    always @* begin
        o_crc = i_crc ^ {8'h00, i_byte};
        for (n = 0; n < 8; n = n + 1) begin
            if (o_crc[0]) begin
                o_crc = (o_crc >> 1) ^ `CRC_POLY;
            end else begin
                o_crc = o_crc >> 1;
            end
        end
    end
endmodule

// file: hw/hex_char_codec.v
// Purpose: ASCII hex character decode and nibble encode
// Assumes: Either letter case accepted on input
// Notes:   Encoder emits upper case digits
`timescale 1ns/1ps
module hex_char_codec (
    input  wire [6:0] i_char,
    input  wire [3:0] i_nib,
    output reg  [3:0] o_nib,
    output reg        o_is_hex,
    output wire [7:0] o_char
);
    // Decode one character to a nibble
    always @* begin
        o_is_hex = 1'b1;
        o_nib    = 4'h0;
        if (i_char >= 7'h30 && i_char <= 7'h39) begin
            o_nib = i_char[3:0];
        end else if ((i_char >= 7'h41 && i_char <= 7'h46) ||
                     (i_char >= 7'h61 && i_char <= 7'h66)) begin
            o_nib = i_char[3:0] + 4'h9;
        end else begin
            o_is_hex = 1'b0;
        end
    end

    // Encode a nibble as '0'..'9' or 'A'..'F'
    assign o_char = (i_nib < 4'ha) ? {4'h3, i_nib} : {4'h4, i_nib - 4'h9};
endmodule

// file: dv/msg_framer_props.sv
// Purpose: Port assertions of the message framer
// Assumes: One clock, synchronous reset
// Notes:   Format and address shadowed from writes
`timescale 1ns/1ps
module msg_framer_props (
    input wire       i_sys_clk,
    input wire       i_nrst,
    input wire [1:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire       i_reg_wr,
    input wire [7:0] o_tx_data,
    input wire       o_tx_valid,
    input wire       i_tx_ready,
    input wire       o_frame_rdy,
    input wire       i_proc_grant,
    input wire       o_req,
    input wire [7:0] o_cmd,
    input wire [4:0] o_count
);
    reg [6:0] sta_q;
    reg       rtu_q;
    reg       lf_q;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    // In ASCII format, after an LF has gone out, the next character opens a new frame
    always @(posedge i_sys_clk) begin
        if (!i_nrst) begin
            sta_q <= 7'h00;
            rtu_q <= 1'b0;
            lf_q <= 1'b1;
        end else begin
            if (i_reg_wr && i_reg_addr == 2'h1) sta_q <= i_reg_wdata[6:0];
            if (i_reg_wr && i_reg_addr == 2'h0) rtu_q <= i_reg_wdata[0];
            if (o_tx_valid && i_tx_ready) lf_q <= o_tx_data[6:0] == 7'h0a;
        end
    end
    a_req_after_grant: assert property (o_req |-> $past(o_frame_rdy && i_proc_grant))
        else $error("request without grant");
    a_rdy_waits: assert property (o_frame_rdy && !i_proc_grant |=> o_frame_rdy)
        else $error("frame ready dropped without grant");
    a_grant_taken: assert property (o_frame_rdy && i_proc_grant |=> !o_frame_rdy)
        else $error("frame ready stayed after grant");
    a_cmd_known: assert property (o_req |-> o_cmd == 8'h03 || o_cmd == 8'h10)
        else $error("request for unknown command");
    a_count_limit: assert property (o_req |-> o_count inside {[5'h01:5'h10]})
        else $error("request count out of range");
    a_tx_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_data))
        else $error("character changed while stalled");
    a_zero_silent: assert property (sta_q == 7'h00 |-> !o_tx_valid && !o_frame_rdy)
        else $error("activity at station zero");
    a_ascii_colon: assert property (o_tx_valid && lf_q && !rtu_q |-> o_tx_data[6:0] == 7'h3a)
        else $error("frame not opened by colon");
    c_req: cover property (o_req);
    c_stall: cover property (o_tx_valid && !i_tx_ready);
    c_rtu_grant: cover property (o_frame_rdy && i_proc_grant && rtu_q);
endmodule
bind msg_framer msg_framer_props u_props (.*);

// file: dv/host_master.sv
// Purpose: Host master on the far side of the serial line
// Assumes: One character per valid pulse; random transmit stalls
// Notes:   Frame builder also predicts replies
`timescale 1ns/1ps
module host_master (
    input  wire       i_sys_clk,
    output reg  [7:0] o_rx_data = 8'h00,
    output reg        o_rx_valid = 1'b0,
    input  wire [7:0] i_tx_data,
    input  wire       i_tx_valid,
    output reg        o_tx_ready = 1'b0
);
    typedef byte unsigned bq_t[$];
    bq_t got;
    // Random stalls make the framer hold its current character while ready is low
    always @(posedge i_sys_clk) begin
        if (i_tx_valid && o_tx_ready)
            got.push_back(i_tx_data);
        o_tx_ready <= ($urandom % 3) != 0;
    end
    function automatic byte unsigned hx(bit [3:0] n);
        return n < 10 ? 8'h30 + n : 8'h37 + n;
    endfunction
    // Register kept unswapped, so its low byte is sent first
    function automatic bit [15:0] crc16(bq_t b);
        bit [15:0] c = 16'hffff;
        foreach (b[i]) begin
            c ^= b[i];
            for (int k = 0; k < 8; k++)
                c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction
    // Wraps bytes into a frame; bad spoils the checksum
    function automatic bq_t build(bit asc, bq_t b, bit bad);
        bq_t q;
        byte unsigned s = 8'h00;
        bit [15:0] c = crc16(b);
        if (!asc)
            return {b, c[7:0] ^ 8'(bad), c[15:8]};
        q.push_back(8'h3a);
        foreach (b[i]) begin
            s += b[i];
            q.push_back(hx(b[i][7:4]));
            q.push_back(hx(b[i][3:0]));
        end
        s = -s ^ 8'(bad);
        return {q, hx(s[7:4]), hx(s[3:0]), 8'h0d, 8'h0a};
    endfunction
    // Between characters the line shows the inverse of the last one
    task automatic send(bq_t q);
        foreach (q[i]) begin
            @(posedge i_sys_clk);
            o_rx_data <= q[i];
            o_rx_valid <= 1'b1;
            @(posedge i_sys_clk);
            o_rx_valid <= 1'b0;
            o_rx_data <= ~q[i];
        end
    endtask
endmodule

// file: dv/serial_slave_message_framer_tb_top.sv
// Purpose: Self-checking bench of the message framer
// Assumes: Millisecond scaled down to 20 cycles
// Notes:   Replies predicted from request bytes
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
    $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
module serial_slave_message_framer_tb_top;
    typedef byte unsigned bq_t[$];
    localparam int CPM = 20;
    reg        clk = 1'b0;
    reg        nrst = 1'b0;
    reg [1:0]  reg_addr = 2'h0;
    reg [7:0]  reg_wdata = 8'h00;
    reg        reg_wr = 1'b0;
    reg        reg_rd = 1'b0;
    reg        grant = 1'b0;
    reg [3:0]  wd_idx = 4'h0;
    reg [7:0]  rsp_data = 8'h00;
    reg        rsp_valid = 1'b0;
    reg        rsp_last = 1'b0;
    wire [7:0] reg_rdata, rx_data, tx_data, cmd;
    wire       rx_valid, tx_valid, tx_ready, frame_rdy, req, rsp_rdy;
    wire [15:0] start, wd;
    wire [4:0] count;
    int        failures = 0;
    int        num_checks = 0;
    bq_t       b, app, q;
    always #2.5 clk = ~clk;
    msg_framer #(.CYC_PER_MS(CPM)) u_dut (.i_sys_clk(clk), .i_nrst(nrst),
        .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
        .o_reg_rdata(reg_rdata), .i_rx_data(rx_data), .i_rx_valid(rx_valid),
        .o_tx_data(tx_data), .o_tx_valid(tx_valid), .i_tx_ready(tx_ready),
        .o_frame_rdy(frame_rdy), .i_proc_grant(grant), .o_req(req), .o_cmd(cmd),
        .o_start(start), .o_count(count), .i_wd_idx(wd_idx), .o_wd(wd),
        .i_rsp_data(rsp_data), .i_rsp_valid(rsp_valid), .i_rsp_last(rsp_last),
        .o_rsp_rdy(rsp_rdy));
    host_master u_host (.i_sys_clk(clk), .o_rx_data(rx_data), .o_rx_valid(rx_valid),
        .i_tx_data(tx_data), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready));
    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Long enough for every frame at the slowest idle time
    initial begin
        #(5 * 60000);
        failures++;
        end_sim;
    end
    task automatic wr(bit [1:0] a, bit [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(bit [1:0] a, bit [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, e)
    endtask
    // Sends f, then grants, feeds the reply body and compares the line
    task automatic txn(bit asc, bq_t f, bit ok, int ms, string name);
        bq_t exp;
        bit good;
        int n;
        if (!(b[1] inside {8'h03, 8'h10}))
            exp = {b[1] | 8'h80, 8'h01};
        else if ({b[4], b[5]} == 0 || {b[4], b[5]} > 16)
            exp = {b[1] | 8'h80, 8'h03};
        else
            exp = app;
        good = exp[0] < 8'h80;
        exp = u_host.build(asc, {b[0], exp}, 0);
        if (!ok)
            exp.delete();
        u_host.got.delete();
        u_host.send(f);
        n = 0;
        while (frame_rdy !== 1'b1 && n < 600) begin
            @(negedge clk);
            n++;
        end
        if (!ok)
            `CHK(frame_rdy, 1'b0)
        else begin
            if (asc)
                `CHK(n <= 4, 1'b1)
            else
                `CHK(n >= (ms - 1) * CPM && n <= (ms + 1) * CPM, 1'b1)
            @(posedge clk);
            grant <= 1'b1;
            @(posedge clk);
            grant <= 1'b0;
            @(negedge clk);
            `CHK(req, good)
            if (good) begin
                `CHK({cmd, start, count}, {b[1], b[2], b[3], b[5][4:0]})
                if (b[1] == 8'h10) begin
                    @(posedge clk);
                    wd_idx <= 4'h1;
                    @(posedge clk);
                    #1 `CHK(wd, {b[9], b[10]})
                end
                foreach (app[i]) begin
                    @(posedge clk);
                    rsp_data <= app[i];
                    rsp_valid <= 1'b1;
                    rsp_last <= i == app.size() - 1;
                    do @(negedge clk); while (rsp_rdy !== 1'b1);
                end
                @(posedge clk);
                rsp_valid <= 1'b0;
                rsp_last <= 1'b0;
            end
        end
        n = 0;
        while (u_host.got.size() < exp.size() && n < 400) begin
            @(posedge clk);
            n++;
        end
        `CHK(u_host.got.size(), exp.size())
        foreach (exp[i])
            `CHK(u_host.got[i], exp[i])
        $display("test %s done", name);
    endtask
    initial begin
        void'($urandom(32'h7e53));
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rd(2'h0, 8'h04);
        rd(2'h1, 8'h00);
        b = {8'h00, 8'h03, 8'h00, 8'h10, 8'h00, 8'h01};
        txn(1, u_host.build(1, b, 0), 0, 0, "silent");
        wr(2'h1, 8'h0a);
        rd(2'h1, 8'h0a);
        wr(2'h3, 8'h00);
        b = {8'h0a, 8'h03, 8'($urandom), 8'($urandom), 8'h00, 8'h02};
        app = {8'h03, 8'h04, 8'h03, 8'h01, 8'h00, 8'h03};
        txn(1, u_host.build(1, b, 0), 1, 0, "ascii read");
        txn(1, {8'h3a, 8'h30, 8'h41, u_host.build(1, b, 0)}, 1, 0, "restart");
        txn(1, u_host.build(1, b, 1), 0, 0, "bad lrc");
        q = u_host.build(1, b, 0);
        q[5] = 8'h47;
        txn(1, q, 0, 0, "non hex");
        b[0] = 8'h0b;
        txn(1, u_host.build(1, b, 0), 0, 0, "other station");
        rd(2'h3, 8'h02);
        b = {8'h0a, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01};
        txn(1, u_host.build(1, b, 0), 1, 0, "ascii error");
        for (int r = 0; r < 4; r++) begin
            wr(2'h0, {5'h00, 2'(r), 1'b1});
            if (r == 3)
                wr(2'h1, 8'h01);
            case (r)
                0: b = {8'h0a, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01};
                1: b = {8'h0a, 8'h03, 8'h00, 8'h00, 8'h00, 8'h11};
                2: b = {8'h0a, 8'h03, 8'h03, 8'he9, 8'h00, 8'h02};
                default: b = {8'h01, 8'h10, 8'h05, 8'hdd, 8'h00, 8'h02, 8'h04,
                    8'h01, 8'ha0, 8'h0e, 8'h53};
            endcase
            if (r == 3)
                app = {8'h10, 8'h05, 8'hdd, 8'h00, 8'h02};
            txn(0, u_host.build(0, b, 0), 1, 16 >> r, "rtu");
        end
        end_sim;
    end
endmodule
